// *** pfm_port34_mux.sv ***
// Purpose: Pin function multiplexer for two eight-bit ports (port 3 and port 4).
// Assumes: Configuration bits and peripheral signals come from logic on clock_i;
//          pad inputs are asynchronous and are synchronised here.
// Notes: Every output is registered, so a configuration change shows one edge later.
//
// How it works
// - Select and analog clear: direction picks I/O.
// - Either reset returns all pins to I/O.
// - Serial select: serial module owns pin direction.
// - Pin 0: unit A clock beats B enable.
// - Pin 0 claimed: unit B forced three-wire.
// - Pin 3: unit B clock wins, A three-wire.
// - First bank: analog, no driver, no buffer.
// - Second bank: analog on port 4 pins.
// - Port 4 pins 0-2: capture A / compare.
// - Port 4 pins 3-4: capture B / compare.
// - Port 4 pin 5 outputs channel 2.
// - Port 3 pins 0-5 map serial signals.
module pfm_port34_mux
    import pfm_pkg::*;
(
    input wire logic clock_i,
    input wire logic arst_n_i,
    input wire logic power_up_clear_i,
    input wire logic [7:0] port3_direction_bits_i,
    input wire logic [7:0] port3_function_select_bits_i,
    input wire logic [7:0] port4_direction_bits_i,
    input wire logic [7:0] port4_function_select_bits_i,
    input wire logic [7:0] analog_enable_bank_first_i,
    input wire logic [7:0] analog_enable_bank_second_i,
    input wire logic [7:0] port3_out_bits_i,
    input wire logic [7:0] port4_out_bits_i,
    input wire logic [7:0] port3_pad_i,
    input wire logic [7:0] port4_pad_i,
    input wire logic [5:0] serial_pin_out_i,
    input wire logic [5:0] serial_pin_drive_i,
    input wire logic serial_a_clock_claim_i,
    input wire logic serial_b_clock_claim_i,
    input wire logic [2:0] timerb_compare_out_i,
    output logic [7:0] port3_pad_o,
    output logic [7:0] port3_pad_oe_n_o,
    output logic [7:0] port4_pad_o,
    output logic [7:0] port4_pad_oe_n_o,
    output logic [7:0] port3_in_bits_o,
    output logic [7:0] port4_in_bits_o,
    output logic [7:0] port3_analog_o,
    output logic [7:0] port4_analog_o,
    output logic [5:0] serial_pin_in_o,
    output logic serial_a_slave_enable_o,
    output logic serial_b_slave_enable_o,
    output logic serial_a_force_3wire_o,
    output logic serial_b_force_3wire_o,
    output logic [2:0] timerb_capture_in_a_o,
    output logic [1:0] timerb_capture_in_b_o
);

    // ==================================================================
    // Pad input synchronisers
    // ==================================================================
    // Two flops give a metastable pad level a full cycle to settle before any
    // selection logic sees it; the price is two extra edges of input latency.
    logic [7:0] p3_meta_reg;
    logic [7:0] p3_sync_reg;
    logic [7:0] p4_meta_reg;
    logic [7:0] p4_sync_reg;

    always_ff @(posedge clock_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            p3_meta_reg <= PFM_RST_BYTE;
            p3_sync_reg <= PFM_RST_BYTE;
            p4_meta_reg <= PFM_RST_BYTE;
            p4_sync_reg <= PFM_RST_BYTE;
        end
        else
        begin
            p3_meta_reg <= port3_pad_i;
            p3_sync_reg <= p3_meta_reg;
            p4_meta_reg <= port4_pad_i;
            p4_sync_reg <= p4_meta_reg;
        end
    end

    // ==================================================================
    // Port 3 selection
    // ==================================================================
    // Analog enable outranks direction and select on the three analog pins.
    wire [7:0] p3_an = {analog_enable_bank_first_i[PFM_AE1_P3_PIN7],
                        analog_enable_bank_first_i[PFM_AE1_P3_PIN6],
                        5'h00,
                        analog_enable_bank_first_i[PFM_AE1_P3_PIN0]};
    wire [7:0] p3_ser = port3_function_select_bits_i & ~p3_an & PFM_P3_SERIAL_MASK;

    // The shared pins drive only for the clock; the slave enable is an input here.
    // A unit that loses its shared pin keeps running; only its slave enable is held
    // low, and the forced three-wire level below tells it why.
    wire [5:0] ser_drive_gate = {2'b11, serial_b_clock_claim_i, 2'b11,
                                 serial_a_clock_claim_i};
    wire [5:0] ser_drive = serial_pin_drive_i & ser_drive_gate;

    wire [7:0] p3_drive_next;
    wire [7:0] p3_val_next;
    genvar gi;
    generate
        for (gi = 0; gi < PFM_PORT_W; gi++)
        begin : g_p3
            if (gi < 6)
            begin : g_ser
                assign p3_drive_next[gi] = ~p3_an[gi] & (p3_ser[gi] ? ser_drive[gi]
                                           : port3_direction_bits_i[gi]);
                assign p3_val_next[gi] = p3_ser[gi] ? serial_pin_out_i[gi]
                                         : port3_out_bits_i[gi];
            end
            else
            begin : g_io
                assign p3_drive_next[gi] = ~p3_an[gi] & port3_direction_bits_i[gi];
                assign p3_val_next[gi] = port3_out_bits_i[gi];
            end
        end
    endgenerate

    wire [7:0] p3_in_next = p3_sync_reg & ~p3_an;
    wire [5:0] ser_in_next = p3_sync_reg[5:0] & p3_ser[5:0];
    wire a_clk_sel = p3_ser[PFM_P3_A_CLOCK_PIN] & serial_a_clock_claim_i;
    wire b_clk_sel = p3_ser[PFM_P3_B_CLOCK_PIN] & serial_b_clock_claim_i;
    // A slave enable follows the pad only while the other unit leaves the pin
    // alone; a claimed clock pin reads as an inactive enable.
    wire b_ste_next = p3_ser[PFM_P3_A_CLOCK_PIN] & ~serial_a_clock_claim_i
                      & p3_sync_reg[PFM_P3_A_CLOCK_PIN];
    wire a_ste_next = p3_ser[PFM_P3_B_CLOCK_PIN] & ~serial_b_clock_claim_i
                      & p3_sync_reg[PFM_P3_B_CLOCK_PIN];

    // ==================================================================
    // Port 4 selection
    // ==================================================================
    wire [7:0] p4_an = {1'b0, 1'b0,
                        analog_enable_bank_second_i[PFM_AE2_P4_PIN5],
                        analog_enable_bank_second_i[PFM_AE2_P4_PIN4],
                        analog_enable_bank_second_i[PFM_AE2_P4_PIN3],
                        3'h0};
    // Pins 6 and 7 carry no timer function in this block and stay plain I/O.
    wire [7:0] p4_tmr = port4_function_select_bits_i & ~p4_an & PFM_P4_TIMER_MASK;
    // Pin 5 takes channel 2, as the function table gives it.
    wire [7:0] p4_cmp = {2'b00, timerb_compare_out_i[2], timerb_compare_out_i[1:0],
                         timerb_compare_out_i};
    wire [7:0] p4_drive_next = ~p4_an & port4_direction_bits_i;
    wire [7:0] p4_val_next = (p4_tmr & port4_direction_bits_i & p4_cmp)
                             | (~p4_tmr & port4_out_bits_i);
    wire [7:0] p4_in_next = p4_sync_reg & ~p4_an;
    // Pin 5 has no capture input, so a select with direction 0 leaves it a
    // plain input; its pad level still reaches the input bits.
    wire [7:0] p4_cap = p4_sync_reg & p4_tmr & ~port4_direction_bits_i;

    // ==================================================================
    // Output registers
    // ==================================================================
    // Power-up clear is synchronous and, like the asynchronous reset, parks every
    // pin as a plain input so nothing is driven until software chooses.
    // Under clear the input bits keep following the pads, since software may
    // read a pin level before it configures anything.
    always_ff @(posedge clock_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            port3_pad_o <= PFM_RST_BYTE;
            port3_pad_oe_n_o <= PFM_RST_OE_N;
            port4_pad_o <= PFM_RST_BYTE;
            port4_pad_oe_n_o <= PFM_RST_OE_N;
            port3_in_bits_o <= PFM_RST_BYTE;
            port4_in_bits_o <= PFM_RST_BYTE;
            port3_analog_o <= PFM_RST_BYTE;
            port4_analog_o <= PFM_RST_BYTE;
            serial_pin_in_o <= PFM_RST_SERIAL;
            serial_a_slave_enable_o <= 1'b0;
            serial_b_slave_enable_o <= 1'b0;
            serial_a_force_3wire_o <= 1'b0;
            serial_b_force_3wire_o <= 1'b0;
            timerb_capture_in_a_o <= 3'h0;
            timerb_capture_in_b_o <= 2'h0;
        end
        else if (power_up_clear_i)
        begin
            port3_pad_o <= PFM_RST_BYTE;
            port3_pad_oe_n_o <= PFM_RST_OE_N;
            port4_pad_o <= PFM_RST_BYTE;
            port4_pad_oe_n_o <= PFM_RST_OE_N;
            port3_in_bits_o <= p3_sync_reg;
            port4_in_bits_o <= p4_sync_reg;
            port3_analog_o <= PFM_RST_BYTE;
            port4_analog_o <= PFM_RST_BYTE;
            serial_pin_in_o <= PFM_RST_SERIAL;
            serial_a_slave_enable_o <= 1'b0;
            serial_b_slave_enable_o <= 1'b0;
            serial_a_force_3wire_o <= 1'b0;
            serial_b_force_3wire_o <= 1'b0;
            timerb_capture_in_a_o <= 3'h0;
            timerb_capture_in_b_o <= 2'h0;
        end
        else
        begin
            port3_pad_o <= p3_val_next;
            port3_pad_oe_n_o <= ~p3_drive_next;
            port4_pad_o <= p4_val_next;
            port4_pad_oe_n_o <= ~p4_drive_next;
            port3_in_bits_o <= p3_in_next;
            port4_in_bits_o <= p4_in_next;
            port3_analog_o <= p3_an;
            port4_analog_o <= p4_an;
            serial_pin_in_o <= ser_in_next;
            serial_a_slave_enable_o <= a_ste_next;
            serial_b_slave_enable_o <= b_ste_next;
            serial_a_force_3wire_o <= b_clk_sel;
            serial_b_force_3wire_o <= a_clk_sel;
            timerb_capture_in_a_o <= p4_cap[2:0];
            timerb_capture_in_b_o <= p4_cap[4:3];
        end
    end

endmodule : pfm_port34_mux

// *** pfm_pkg.sv ***
// Purpose: Shared constants for the port 3 / port 4 pin function multiplexer.
// Assumes: Ports are eight pins wide; bit positions below index pins or analog-enable bits.
// Notes: All masks are per pin, bit n standing for pin n.
package pfm_pkg;

    // ==================================================================
    // Widths
    // ==================================================================
    localparam int PFM_PORT_W = 8;
    localparam int PFM_SYNC_STAGES = 2;

    // ==================================================================
    // Analog-enable bit positions
    // ==================================================================
    // Port 3 pins 0, 6 and 7 use bits 5, 6 and 7 of the first bank.
    localparam int PFM_AE1_P3_PIN0 = 5;
    localparam int PFM_AE1_P3_PIN6 = 6;
    localparam int PFM_AE1_P3_PIN7 = 7;
    // Port 4 pins 3, 4 and 5 use bits 4, 5 and 6 of the second bank.
    localparam int PFM_AE2_P4_PIN3 = 4;
    localparam int PFM_AE2_P4_PIN4 = 5;
    localparam int PFM_AE2_P4_PIN5 = 6;

    // ==================================================================
    // Pin masks
    // ==================================================================
    localparam logic [7:0] PFM_P3_SERIAL_MASK = 8'h3f;
    localparam logic [7:0] PFM_P4_TIMER_MASK = 8'h3f;

    // ==================================================================
    // Shared pin positions on port 3
    // ==================================================================
    localparam int PFM_P3_A_CLOCK_PIN = 0;
    localparam int PFM_P3_B_CLOCK_PIN = 3;

    // ==================================================================
    // Reset values of registered outputs
    // ==================================================================
    localparam logic [7:0] PFM_RST_BYTE = 8'h00;
    localparam logic [7:0] PFM_RST_OE_N = 8'hff;
    localparam logic [5:0] PFM_RST_SERIAL = 6'h00;

endpackage : pfm_pkg

// *** pfm_properties.sv ***
// Purpose: Concurrent checks on the pin multiplexer ports.
// Assumes: One clock; an output follows configuration and peripheral inputs one edge later, pads three edges later.
// Notes: Bound to the design below; only the ports that the checks need are listed.
module pfm_properties (
    input wire logic clock_i,
    input wire logic arst_n_i,
    input wire logic power_up_clear_i,
    input wire logic [7:0] port3_direction_bits_i,
    input wire logic [7:0] port3_function_select_bits_i,
    input wire logic [7:0] port4_direction_bits_i,
    input wire logic [7:0] port4_function_select_bits_i,
    input wire logic [7:0] analog_enable_bank_first_i,
    input wire logic [7:0] analog_enable_bank_second_i,
    input wire logic [7:0] port3_out_bits_i,
    input wire logic [5:0] serial_pin_out_i,
    input wire logic [5:0] serial_pin_drive_i,
    input wire logic serial_a_clock_claim_i,
    input wire logic serial_b_clock_claim_i,
    input wire logic [2:0] timerb_compare_out_i,
    input wire logic [7:0] port3_pad_o,
    input wire logic [7:0] port3_pad_oe_n_o,
    input wire logic [7:0] port4_pad_o,
    input wire logic [7:0] port4_pad_oe_n_o,
    input wire logic [7:0] port3_analog_o,
    input wire logic [7:0] port4_analog_o,
    input wire logic serial_a_slave_enable_o,
    input wire logic serial_b_slave_enable_o,
    input wire logic serial_a_force_3wire_o,
    input wire logic serial_b_force_3wire_o
);
    // ==========
    // Checks
    // Clear parks every output but the input bits at the edge it is seen, so it disables the mapping checks.
    default clocking cb @(posedge clock_i);
    endclocking
    default disable iff (!arst_n_i || power_up_clear_i);
    a_gpio_drive: assert property (!port3_function_select_bits_i[2]
        && port3_direction_bits_i[2] |=> !port3_pad_oe_n_o[2]
        && port3_pad_o[2] == $past(port3_out_bits_i[2])) else $error("gpio pin not driven");
    a_serial_dir: assert property (port3_function_select_bits_i[1]
        |=> port3_pad_oe_n_o[1] != $past(serial_pin_drive_i[1]) && (port3_pad_oe_n_o[1]
        || port3_pad_o[1] == $past(serial_pin_out_i[1]))) else $error("serial pin wrong");
    a_clear_parks: assert property (disable iff (!arst_n_i) power_up_clear_i
        |=> (port3_pad_oe_n_o & port4_pad_oe_n_o) == 8'hff
        && (port3_analog_o | port4_analog_o) == 8'h00) else $error("clear did not park");
    a_a_clock_wins: assert property (port3_function_select_bits_i[0]
        && !analog_enable_bank_first_i[5] && serial_a_clock_claim_i
        |=> serial_b_force_3wire_o && !serial_b_slave_enable_o) else $error("unit A clock lost");
    a_b_clock_wins: assert property (port3_function_select_bits_i[3]
        && serial_b_clock_claim_i
        |=> serial_a_force_3wire_o && !serial_a_slave_enable_o) else $error("unit B clock lost");
    a_first_bank: assert property (analog_enable_bank_first_i[7]
        |=> port3_pad_oe_n_o[7] && port3_analog_o[7]) else $error("pin 7 not analog");
    a_second_bank: assert property (analog_enable_bank_second_i[6]
        |=> port4_pad_oe_n_o[5] && port4_analog_o[5]) else $error("port 4 pin 5 not analog");
    a_timer_chan1: assert property (port4_function_select_bits_i[4]
        && port4_direction_bits_i[4] && !analog_enable_bank_second_i[5] |=> !port4_pad_oe_n_o[4]
        && port4_pad_o[4] == $past(timerb_compare_out_i[1])) else $error("compare 1 not out");
endmodule : pfm_properties

bind pfm_port34_mux pfm_properties i_pfm_properties (.*);

// *** pfm_partner.sv ***
// Purpose: Behavioural serial units and timer beside the multiplexer.
// Assumes: The bench offers a fresh word before each rising edge.
// Notes: While hold_i is high the outputs stand still, as a slow module would.
module pfm_partner (
    input wire logic clock_i,
    input wire logic hold_i,
    input wire logic [16:0] stim_i,
    output logic [5:0] pin_out_o,
    output logic [5:0] pin_drive_o,
    output logic a_claim_o,
    output logic b_claim_o,
    output logic [2:0] compare_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [16:0] word;
    // ==========
    // Outputs
    // The word is taken at the edge and shown 1 ns later, so the design never races it.
    initial {pin_out_o, pin_drive_o, a_claim_o, b_claim_o, compare_o} = 17'h0_0000;
    always @(posedge clock_i)
    begin
        word = stim_i;
        if (!hold_i)
            #1 {pin_out_o, pin_drive_o, a_claim_o, b_claim_o, compare_o} = word;
    end
endmodule : pfm_partner

// *** tb_top.sv ***
// Purpose: Self-checking bench for the port 3 / port 4 pin multiplexer.
// Assumes: Inputs change 1 ns after the rising edge; outputs are read then too.
// Notes: Configuration comes from a fixed-seed shift register; pads only in the directed part.
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock_i, arst_n_i, power_up_clear_i, stall;
    logic serial_a_clock_claim_i, serial_b_clock_claim_i;
    logic [7:0] port3_direction_bits_i, port3_function_select_bits_i, port4_direction_bits_i;
    logic [7:0] port4_function_select_bits_i, analog_enable_bank_first_i;
    logic [7:0] analog_enable_bank_second_i, port3_out_bits_i, port4_out_bits_i;
    logic [7:0] port3_pad_i, port4_pad_i, port3_pad_o, port4_pad_o, port3_pad_oe_n_o;
    logic [7:0] port4_pad_oe_n_o, port3_in_bits_o, port4_in_bits_o, port3_analog_o;
    logic [7:0] port4_analog_o, e_oe3, e_oe4, e_v3, e_v4, e_an3, e_an4;
    logic [1:0] e_f;
    logic [5:0] serial_pin_in_o, serial_pin_out_i, serial_pin_drive_i;
    logic serial_a_slave_enable_o, serial_b_slave_enable_o;
    logic serial_a_force_3wire_o, serial_b_force_3wire_o;
    logic [2:0] timerb_capture_in_a_o, timerb_compare_out_i;
    logic [1:0] timerb_capture_in_b_o;
    logic [79:0] cfg = '0;
    logic [31:0] rnd = 32'h0000_94a5;
    logic [16:0] stim = '0;
    int error_cnt = 0;
    int checked = 0;
    assign {port3_direction_bits_i, port3_function_select_bits_i, port4_direction_bits_i,
        port4_function_select_bits_i, analog_enable_bank_first_i, analog_enable_bank_second_i,
        port3_out_bits_i, port4_out_bits_i, port3_pad_i, port4_pad_i} = cfg;
    pfm_port34_mux i_pfm_port34_mux (.*);
    pfm_partner i_pfm_partner (.clock_i(clock_i), .hold_i(stall), .stim_i(stim),
        .pin_out_o(serial_pin_out_i), .pin_drive_o(serial_pin_drive_i),
        .a_claim_o(serial_a_clock_claim_i), .b_claim_o(serial_b_clock_claim_i),
        .compare_o(timerb_compare_out_i));
    // ==========
    // Helpers
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        for (int i = 0; i < 32; i++)
            x = {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
        return x;
    endfunction : lfsr
    // Shared clock pins drive only while their unit claims them as clock.
    function automatic void predict();
        logic drv;
        e_an3 = {analog_enable_bank_first_i[7:6], 5'h00, analog_enable_bank_first_i[5]};
        e_an4 = {2'b00, analog_enable_bank_second_i[6:4], 3'h0} & {8{!power_up_clear_i}};
        e_f = {port3_function_select_bits_i[3] && serial_b_clock_claim_i,
            port3_function_select_bits_i[0] && !analog_enable_bank_first_i[5]
            && serial_a_clock_claim_i} & {2{!power_up_clear_i}};
        e_an3 = e_an3 & {8{!power_up_clear_i}};
        for (int n = 0; n < 8; n++)
        begin
            drv = port3_direction_bits_i[n];
            e_v3[n] = port3_out_bits_i[n];
            if (port3_function_select_bits_i[n] && n < 6)
            begin
                drv = serial_pin_drive_i[n] && (n == 0 ? serial_a_clock_claim_i
                    : n == 3 ? serial_b_clock_claim_i : 1'b1);
                e_v3[n] = serial_pin_out_i[n];
            end
            e_oe3[n] = !drv || e_an3[n] || power_up_clear_i;
            e_v4[n] = port4_out_bits_i[n];
            if (port4_function_select_bits_i[n] && n < 6)
                e_v4[n] = timerb_compare_out_i[n < 3 ? n : n == 5 ? 2 : n - 3];
            e_oe4[n] = !port4_direction_bits_i[n] || e_an4[n] || power_up_clear_i;
        end
    endfunction : predict
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic wrap_up();
        $display("checks %0d, mismatches %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : wrap_up
    task automatic do_reset();
        arst_n_i = 1'b0;
        repeat (5) @(posedge clock_i);
        #1;
        check({port3_pad_oe_n_o, port4_pad_oe_n_o}, 16'hffff);
        check({port3_in_bits_o, port4_analog_o}, 16'h0000);
        arst_n_i = 1'b1;
    endtask : do_reset
    // ==========
    // Sequence
    initial
    begin
        clock_i = 1'b0;
        forever #2.5 clock_i = ~clock_i;
    end
    // The run needs about 315 cycles; over twelve times that means a hang.
    initial
    begin
        #20000;
        error_cnt++;
        wrap_up();
    end
    initial
    begin
        {arst_n_i, power_up_clear_i, stall} = 3'b000;
        do_reset();
        repeat (300)
        begin
            rnd = lfsr(rnd);
            cfg[79:48] = rnd;
            rnd = lfsr(rnd);
            cfg[47:16] = rnd;
            rnd = lfsr(rnd);
            stim = rnd[16:0];
            power_up_clear_i = rnd[31:27] == 5'h00;
            stall = &rnd[26:24];
            #3;
            predict();
            @(posedge clock_i);
            #1;
            check({port3_pad_oe_n_o, port4_pad_oe_n_o}, {e_oe3, e_oe4});
            check({port3_pad_o & ~e_oe3, port4_pad_o & ~e_oe4},
                {e_v3 & ~e_oe3, e_v4 & ~e_oe4});
            check({port3_analog_o, port4_analog_o}, {e_an3, e_an4});
            check({14'h0000, serial_a_force_3wire_o, serial_b_force_3wire_o},
                {14'h0000, e_f});
        end
        {power_up_clear_i, stall, stim} = '0;
        cfg = 80'h0028_0019_8000_0000_ff19;
        repeat (3) @(posedge clock_i);
        #1;
        check({port3_in_bits_o, port4_in_bits_o}, 16'h7f19);
        check({serial_pin_in_o, timerb_capture_in_a_o, timerb_capture_in_b_o, 5'h00},
            {6'h28, 3'h1, 2'h3, 5'h00});
        check({12'h000, serial_a_slave_enable_o, serial_b_slave_enable_o,
            serial_a_force_3wire_o, serial_b_force_3wire_o}, 16'h0008);
        power_up_clear_i = 1'b1;
        cfg[79:72] = 8'hff;
        @(posedge clock_i);
        #1;
        check({port3_pad_oe_n_o, port4_pad_oe_n_o}, 16'hffff);
        do_reset();
        wrap_up();
    end
endmodule : tb_top
